//--- hw/lcdp_cfg.svh
/*
 * constants for the display-side four-bit port and the eight-bit input port:
 * register indices, reset values, field layout and converter channel codes.
 * assumes: included by its bare name from every design file that needs it.
 */
`ifndef LCDP_CFG_SVH
`define LCDP_CFG_SVH

`define LCDP_ADDR_W       18
`define LCDP_IDX_DATA     16'hffdd
`define LCDP_IDX_LEVELS   16'hffde
`define LCDP_IDX_DIR      16'hffed
`define LCDP_DATA_RST     8'hf0
`define LCDP_DIR_RST      8'hf0
`define LCDP_PORT_W       4
`define LCDP_INPORT_W     8
`define LCDP_UPPER_ONES   4'hf
`define LCDP_DIR_READ     8'hff
`define LCDP_RSVD_READ    4'h0
`define LCDP_CH_BASE      4'h4
`define LCDP_AN_W         4

`endif

//--- hw/lcdp_pkg.sv
/*
 * types shared by the port block: power modes and the pin drive bundle.
 * assumes: lcdp_cfg.svh is on the include path.
 */
`default_nettype none
`include "lcdp_cfg.svh"
package lcdp_pkg;

   // operating mode given by the system controller, one-hot
   typedef enum logic [5:0] {
      LCDP_ACTIVE    = 6'b000001,
      LCDP_SUBACTIVE = 6'b000010,
      LCDP_SLEEP     = 6'b000100,
      LCDP_SUBSLEEP  = 6'b001000,
      LCDP_WATCH     = 6'b010000,
      LCDP_STANDBY   = 6'b100000
   } lcdp_pwr_mode_t;

   // one pin's drive: level and active-low enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } lcdp_pin_drv_t;

endpackage
`default_nettype wire

//--- hw/lcdp_sync.sv
/*
 * two-flop synchroniser for a vector of pin levels.
 * assumes: bits are independent levels; no bus coherence is needed.
 */
`default_nettype none
`include "lcdp_cfg.svh"
module lcdp_sync #(
   parameter int W = 4
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         dout    <= '0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule // lcdp_sync
`default_nettype wire

//--- hw/lcdp_pin_drv.sv
/*
 * registered driver for one display-side pin, following the power mode.
 * assumes: mode comes from logic on pclk; illegal codes float the pin.
 */
`default_nettype none
`include "lcdp_cfg.svh"
module lcdp_pin_drv
   import lcdp_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire lcdp_pwr_mode_t mode,
   input  wire logic           dir,
   input  wire logic           data,
   output lcdp_pin_drv_t       drv_ff
);
   lcdp_pin_drv_t nxt_drv;

   // sleep-type modes keep the last drive, standby floats the pin
   always_comb begin
      nxt_drv = drv_ff;
      unique case (mode)
         LCDP_ACTIVE, LCDP_SUBACTIVE: begin
            nxt_drv.out  = data;
            nxt_drv.oe_n = ~dir;
         end
         LCDP_SLEEP, LCDP_SUBSLEEP, LCDP_WATCH: begin
            nxt_drv = drv_ff;
         end
         LCDP_STANDBY: begin
            nxt_drv.oe_n = 1'b1;
         end
         default: begin
            nxt_drv.oe_n = 1'b1;
         end
      endcase
   end

   // pin floats while reset is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_ff <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         drv_ff <= nxt_drv;
      end
   end
endmodule // lcdp_pin_drv
`default_nettype wire

//--- hw/lcdp_ports.sv
/*
 * display-side four-bit bidirectional port and eight-bit input-only port,
 * reached over an apb slave with one aligned word per register.
 * assumes: pwr_mode and converter_channel_select come from logic on pclk;
 * pins come from outside and are synchronised here.
 */
// Implementation choice: the APB interface to the registers.
`default_nettype none
`include "lcdp_cfg.svh"
module lcdp_ports
   import lcdp_pkg::*;
#(
   parameter int    ADDR_W     = `LCDP_ADDR_W,
   parameter int    PORT_W     = `LCDP_PORT_W,
   parameter int    INPORT_W   = `LCDP_INPORT_W,
   parameter bit    HAS_ANALOG = 1'b1
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire lcdp_pwr_mode_t      pwr_mode,
   input  wire logic [3:0]          converter_channel_select,
   input  wire logic [PORT_W-1:0]   lcd_port_pins_i,
   output logic      [PORT_W-1:0]   lcd_port_pins_o,
   output logic      [PORT_W-1:0]   lcd_port_pins_oe_n,
   input  wire logic [INPORT_W-1:0] input_port_pins
);

   // byte addresses are four times the register indices
   localparam logic [ADDR_W-1:0] ADDR_DATA   = ADDR_W'({`LCDP_IDX_DATA, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_LEVELS = ADDR_W'({`LCDP_IDX_LEVELS, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_DIR    = ADDR_W'({`LCDP_IDX_DIR, 2'b00});
   localparam logic [7:0]        DATA_RST    = `LCDP_DATA_RST;
   localparam logic [7:0]        DIR_RST     = `LCDP_DIR_RST;

   logic [PORT_W-1:0]   lcd_port_data_ff;
   logic [PORT_W-1:0]   lcd_port_direction_ff;
   logic [PORT_W-1:0]   lcd_pins_sync;
   logic [INPORT_W-1:0] in_pins_sync;
   logic [INPORT_W-1:0] analog_mask;
   logic [INPORT_W-1:0] input_port_levels;
   logic [7:0]          lcd_read_val;
   logic                setup;
   logic                hit_data;
   logic                hit_levels;
   logic                hit_dir;
   logic                hit_any;
   logic                wr_take;
   logic                pready_ff;
   logic                pslverr_ff;
   logic [31:0]         prdata_ff;
   logic [31:0]         nxt_prdata;
   lcdp_pin_drv_t       drv [PORT_W];

   // pins cross into pclk before any read path sees them
   lcdp_sync #(
      .W (PORT_W)
   ) u_sync_lcd (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (lcd_port_pins_i),
      .dout    (lcd_pins_sync)
   );

   lcdp_sync #(
      .W (INPORT_W)
   ) u_sync_in (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (input_port_pins),
      .dout    (in_pins_sync)
   );

   // address decode; the slave answers in the first access cycle
   assign setup      = psel & ~penable;
   assign hit_data   = (paddr == ADDR_DATA);
   assign hit_levels = (paddr == ADDR_LEVELS);
   assign hit_dir    = (paddr == ADDR_DIR);
   assign hit_any    = hit_data | hit_levels | hit_dir;
   assign wr_take    = psel & penable & pready_ff & pwrite & pstrb[0];

   // converter channel code 4+n sits on input pin n; a selected pin reads zero
   always_comb begin
      analog_mask = '0;
      for (int n = 0; n < `LCDP_AN_W; n++) begin
         if (converter_channel_select == (`LCDP_CH_BASE + 4'(n))) begin
            analog_mask[n] = HAS_ANALOG;
         end
      end
   end

   // input port has no storage: the read is the live synchronised level
   always_comb begin
      input_port_levels = in_pins_sync & ~analog_mask;
      if (!HAS_ANALOG) begin
         input_port_levels[3:0] = `LCDP_RSVD_READ;
      end
   end

   // outputs read back the data register, inputs read the pin
   assign lcd_read_val = {`LCDP_UPPER_ONES,
                          (lcd_port_direction_ff & lcd_port_data_ff) |
                          (~lcd_port_direction_ff & lcd_pins_sync)};

   // read mux, sampled in the setup cycle
   always_comb begin
      nxt_prdata = '0;
      if (hit_data) begin
         nxt_prdata[7:0] = lcd_read_val;
      end else if (hit_levels) begin
         nxt_prdata[7:0] = input_port_levels;
      end else if (hit_dir) begin
         nxt_prdata[7:0] = `LCDP_DIR_READ;
      end
   end

   // ready is high for exactly the first access cycle: no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // read data and error are held only while the answer stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
         pslverr_ff <= ~hit_any;
      end else begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // data register: only the four low bits exist; a write to the input
   // port address falls through and touches nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_port_data_ff <= DATA_RST[PORT_W-1:0];
      end else if (wr_take && hit_data) begin
         lcd_port_data_ff <= pwdata[PORT_W-1:0];
      end
   end

   // direction register, write-only from software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_port_direction_ff <= DIR_RST[PORT_W-1:0];
      end else if (wr_take && hit_dir) begin
         lcd_port_direction_ff <= pwdata[PORT_W-1:0];
      end
   end

   // one registered driver per display-side pin; the input port has none
   for (genvar g = 0; g < PORT_W; g++) begin : g_pin
      lcdp_pin_drv u_drv (
         .pclk    (pclk),
         .presetn (presetn),
         .mode    (pwr_mode),
         .dir     (lcd_port_direction_ff[g]),
         .data    (lcd_port_data_ff[g]),
         .drv_ff  (drv[g])
      );
      assign lcd_port_pins_o[g]    = drv[g].out;
      assign lcd_port_pins_oe_n[g] = drv[g].oe_n;
   end

   // checks on read values, driver behaviour and reset state; the bus checks
   // further down pin the one-cycle answer that the read and write paths rely on,
   // so a wait state added later must revisit them as well

   AST_UPPER_ONES: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_data |=> prdata[7:4] == `LCDP_UPPER_ONES)
      else $error("upper data bits did not read as ones");

   AST_DRIVE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_mode == LCDP_ACTIVE |=>
         lcd_port_pins_oe_n == ~$past(lcd_port_direction_ff) &&
         ((lcd_port_pins_o ^ $past(lcd_port_data_ff)) & ~lcd_port_pins_oe_n) == '0)
      else $error("driven pins do not follow direction and data");

   AST_READ_DRIVEN: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_data |=>
         ((prdata[3:0] ^ $past(lcd_port_data_ff)) & $past(lcd_port_direction_ff)) == '0)
      else $error("output bit did not read back stored data");

   AST_READ_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_data |=>
         ((prdata[3:0] ^ $past(lcd_pins_sync)) & ~$past(lcd_port_direction_ff)) == '0)
      else $error("input bit did not read the pin level");

   AST_RESET_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> {`LCDP_UPPER_ONES, lcd_port_data_ff} == DATA_RST)
      else $error("data register not at reset value");

   AST_RESET_DIR: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> lcd_port_direction_ff == DIR_RST[PORT_W-1:0] &&
                         lcd_port_pins_oe_n == '1)
      else $error("direction register not at reset value");

   AST_DIR_WO: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_dir |=> prdata[7:0] == `LCDP_DIR_READ && pready)
      else $error("direction register read was not all ones");

   AST_STANDBY_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_mode == LCDP_STANDBY |=> lcd_port_pins_oe_n == '1)
      else $error("pin driven in standby");

   AST_SLEEP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_mode inside {LCDP_SLEEP, LCDP_SUBSLEEP, LCDP_WATCH} |=>
         $stable(lcd_port_pins_o) && $stable(lcd_port_pins_oe_n))
      else $error("pin drive changed in a holding mode");

   AST_LEVELS_READ: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_levels |=>
         prdata[7:4] == $past(in_pins_sync[7:4]) && prdata[31:8] == '0)
      else $error("input port did not read live pin levels");

   AST_CHANNEL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_levels && HAS_ANALOG &&
      converter_channel_select == `LCDP_CH_BASE |=> prdata[0] == 1'b0)
      else $error("selected converter channel did not read zero");

   AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_levels && !HAS_ANALOG |=> prdata[3:0] == `LCDP_RSVD_READ)
      else $error("reserved input bits did not read zero");

   AST_LEVELS_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && hit_levels |=>
         $stable(lcd_port_data_ff) && $stable(lcd_port_direction_ff))
      else $error("write to input port changed state");

   // the attempt starting on the release edge is skipped: the flops were still cleared
   AST_SYNC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      presetn ##2 1'b1 |-> in_pins_sync == $past(input_port_pins, 2))
      else $error("input pins not delayed by two flops");

   // display-side pins take the same two-flop path
   AST_SYNC_LCD: assert property (@(posedge pclk) disable iff (!presetn)
      presetn ##2 1'b1 |-> lcd_pins_sync == $past(lcd_port_pins_i, 2))
      else $error("display pins not delayed by two flops");

   AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !hit_any |=> pslverr && pready && prdata == '0)
      else $error("unmapped access not refused");

   // ready answers in the first access cycle, so no wait state is ever seen
   AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready)
      else $error("ready missing in the first access cycle");

   // ready is a one-cycle pulse; a second high cycle would close a phantom transfer
   AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready stayed high for two cycles");

   // the answer only ever stands inside an access phase
   AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> psel && penable)
      else $error("ready raised outside an access cycle");

   // an error is only reported together with the answer
   AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error flag raised without ready");

   // mapped addresses never report an error
   AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
      setup && hit_any |=> !pslverr)
      else $error("mapped access reported an error");

   // read data is cleared outside the answer, so a late sampler sees zero, not stale data
   AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == '0)
      else $error("read data not zero outside the answer");

   // registers are bytes; the upper bus lanes always read zero
   AST_RDATA_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == '0)
      else $error("upper read lanes not zero");

   // a write never returns data
   AST_WRITE_NO_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
      setup && pwrite |=> prdata == '0)
      else $error("write returned read data");

   // a write to the data register lands on the access edge; upper bits are dropped
   AST_WRITE_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      wr_take && hit_data |=> lcd_port_data_ff == $past(pwdata[PORT_W-1:0]))
      else $error("data register did not take the written value");

   // a write to the direction register lands on the access edge
   AST_WRITE_DIR: assert property (@(posedge pclk) disable iff (!presetn)
      wr_take && hit_dir |=> lcd_port_direction_ff == $past(pwdata[PORT_W-1:0]))
      else $error("direction register did not take the written value");

   // only a taken write to the two port registers changes them; this covers the
   // input port address, unmapped addresses and writes with the low strobe off
   AST_NO_STRAY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_take && (hit_data || hit_dir)) |=>
         $stable(lcd_port_data_ff) && $stable(lcd_port_direction_ff))
      else $error("port register changed without a write");

   // subactive drives the pins exactly like active
   AST_SUBACTIVE_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_mode == LCDP_SUBACTIVE |=>
         lcd_port_pins_oe_n == ~$past(lcd_port_direction_ff) &&
         ((lcd_port_pins_o ^ $past(lcd_port_data_ff)) & ~lcd_port_pins_oe_n) == '0)
      else $error("subactive pins do not follow direction and data");

   // standby only floats the pins; the output level is kept for the wake-up
   AST_STANDBY_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_mode == LCDP_STANDBY |=> $stable(lcd_port_pins_o))
      else $error("output level changed in standby");

   // the bus leaves reset silent
   AST_RESET_BUS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !pready && !pslverr && prdata == '0)
      else $error("bus outputs not idle after reset");

   // pin levels leave reset low as well as floating
   AST_RESET_PINS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> lcd_port_pins_o == '0)
      else $error("pin levels not cleared by reset");

endmodule // lcdp_ports
`default_nettype wire

//--- dv/lcdp_pin_model.sv
/*
 * partner model of the pins around the display-side port: each pin shows
 * the port's level while the port drives it, else the outside level.
 * assumes: the bench picks the outside levels; pins have no pull resistor.
 */
`default_nettype none
module lcdp_pin_model (
   input  wire logic [3:0] pins_o,
   input  wire logic [3:0] pins_oe_n,
   input  wire logic [3:0] ext_lvl,
   output logic      [3:0] pins_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // resolve each wire; the outside driver yields while the port drives
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         pins_i[n] = pins_oe_n[n] ? ext_lvl[n] : pins_o[n];
      end
   end
endmodule // lcdp_pin_model
`default_nettype wire

//--- dv/lcdp_ports_test.sv
/*
 * self-checking bench for the two ports: apb master, pin model, random
 * directions, data and pin levels, power modes, converter channels.
 * assumes: zero-wait apb slave; pins synchronised by two flops.
 */
`default_nettype none
`include "lcdp_cfg.svh"
module lcdp_ports_test
   import lcdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [17:0] A_DATA = {`LCDP_IDX_DATA, 2'b00};
   localparam logic [17:0] A_LVL  = {`LCDP_IDX_LEVELS, 2'b00};
   localparam logic [17:0] A_DIR  = {`LCDP_IDX_DIR, 2'b00};
   localparam logic [17:0] A_BAD  = 18'h3fffc;
   logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [17:0]    paddr;
   logic [31:0]    pwdata, prdata, rd, prdata_r, rd2;
   logic [3:0]     pstrb, ch, pins_i, pins_o, pins_oe_n, ext, d, v;
   logic [7:0]     inp;
   lcdp_pwr_mode_t pwr_mode;
   lcdp_pwr_mode_t hold_m [3] = '{LCDP_SLEEP, LCDP_SUBSLEEP, LCDP_WATCH};
   int             n_mismatch, check_count, seed;

   lcdp_ports uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_mode(pwr_mode), .converter_channel_select(ch), .lcd_port_pins_i(pins_i),
      .lcd_port_pins_o(pins_o), .lcd_port_pins_oe_n(pins_oe_n), .input_port_pins(inp));
   lcdp_pin_model pins (.pins_o(pins_o), .pins_oe_n(pins_oe_n), .ext_lvl(ext), .pins_i(pins_i));
   // reduced variant without converter inputs on the same bus; only its read data is watched
   lcdp_ports #(.HAS_ANALOG(1'b0)) uut_rsv (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_r), .pready(), .pslverr(),
      .pwr_mode(pwr_mode), .converter_channel_select(ch), .lcd_port_pins_i(pins_i), .lcd_port_pins_o(),
      .lcd_port_pins_oe_n(), .input_port_pins(inp));

   // free-running 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // a hang costs a mismatch; the run needs well under 2000 cycles
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; holds the request until pready is seen at an edge
   task apb(input logic w, input logic [17:0] a, input logic [31:0] dta);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dta;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      rd2 = prdata_r;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         n_mismatch++;
      end
   endtask

   // outputs read back stored data, inputs the pin level, upper nibble ones
   function automatic logic [31:0] exp_data(logic [3:0] dr, logic [3:0] dt, logic [3:0] pin);
      return {24'h0, `LCDP_UPPER_ONES, (dr & dt) | (~dr & pin)};
   endfunction

   // a pin chosen as converter channel reads zero
   function automatic logic [31:0] exp_lvl(logic [7:0] p, logic [3:0] c);
      if (c >= `LCDP_CH_BASE && c < `LCDP_CH_BASE + 4'h4) begin
         p[c - `LCDP_CH_BASE] = 1'b0;
      end
      return {24'h0, p};
   endfunction

   // main sequence: reset, random port traffic, modes, input port, reset again
   initial begin
      seed = 46;
      n_mismatch = 0;
      check_count = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      pwr_mode = LCDP_ACTIVE;
      ch = 4'h0;
      ext = 4'h5;
      inp = 8'h00;
      wt(2);
      chk(32'(pins_oe_n), 32'hf);
      presetn <= 1'b1;
      wt(3);
      apb(1'b0, A_DATA, 32'h0);
      chk(rd, exp_data(4'h0, 4'h0, ext));
      chk(32'(er), 32'h0);
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
         v = 4'($random(seed));
         @(posedge pclk);
         ext <= 4'($random(seed));
         apb(1'b1, A_DIR, {28'h0, d});
         apb(1'b1, A_DATA, {28'h0, v});
         wt(3);
         chk(32'(pins_oe_n), {28'h0, ~d});
         chk(32'(pins_o), 32'(v));
         apb(1'b0, A_DATA, 32'h0);
         chk(rd, exp_data(d, v, ext));
         apb(1'b0, A_DIR, 32'h0);
         chk(rd, 32'(`LCDP_DIR_READ));
      end
      // low-power modes: sleep-like ones freeze the pins, standby floats them
      apb(1'b1, A_DIR, 32'hf);
      apb(1'b1, A_DATA, 32'ha);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         pwr_mode <= hold_m[i];
         apb(1'b1, A_DATA, 32'h5);
         wt(2);
         chk(32'(pins_o), 32'ha);
         chk(32'(pins_oe_n), 32'h0);
         pwr_mode <= LCDP_ACTIVE;
         wt(2);
         chk(32'(pins_o), 32'h5);
         apb(1'b1, A_DATA, 32'ha);
      end
      pwr_mode <= LCDP_STANDBY;
      wt(2);
      chk(32'(pins_oe_n), 32'hf);
      pwr_mode <= LCDP_SUBACTIVE;
      wt(2);
      chk(32'(pins_oe_n), 32'h0);
      // input-only port with every channel code and some random ones
      for (int i = 0; i < 10; i++) begin
         @(posedge pclk);
         inp <= 8'($random(seed));
         ch <= (i < 5) ? 4'(i + 4) : 4'($random(seed));
         wt(3);
         apb(1'b0, A_LVL, 32'h0);
         chk(rd, exp_lvl(inp, ch));
         chk(rd2, {24'h0, inp[7:4], `LCDP_RSVD_READ});
      end
      apb(1'b1, A_LVL, 32'hff);
      apb(1'b0, A_LVL, 32'h0);
      chk(rd, exp_lvl(inp, ch));
      apb(1'b0, A_DATA, 32'h0);
      chk(rd, exp_data(4'hf, 4'ha, ext));
      apb(1'b0, A_BAD, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      // reset in mid-run with the pins driven
      @(posedge pclk);
      presetn <= 1'b0;
      wt(2);
      chk(32'(pins_oe_n), 32'hf);
      presetn <= 1'b1;
      wt(3);
      apb(1'b0, A_DATA, 32'h0);
      chk(rd, exp_data(4'h0, 4'h0, ext));
      end_of_test();
   end
endmodule // lcdp_ports_test
`default_nettype wire
